/* File: common/sfpe_params.svh */
// constants for the serial flash program and erase link
`ifndef SFPE_PARAMS_SVH
`define SFPE_PARAMS_SVH
`define SFPE_OP_PROG 8'h02
`define SFPE_OP_QPROG 8'h32
`define SFPE_OP_SECT 8'h20
`define SFPE_OP_BLK32 8'h52
`define SFPE_OP_BLK64 8'hD8
`define SFPE_OP_CHIP_A 8'hC7
`define SFPE_OP_CHIP_B 8'h60
`define SFPE_OP_WREN 8'h06
`define SFPE_OP_RDSR 8'h05
`define SFPE_OP_CRRST 8'hFF
`define SFPE_CR_KEEP 2'b10
`define SFPE_ERASED 8'hFF
`define SFPE_PROG_US 3
`define SFPE_SECT_US 30
`define SFPE_BLK32_US 120
`define SFPE_BLK64_US 150
`define SFPE_CHIP_US 400
`define SFPE_LINK_MHZ 33
`define SFPE_CYC(us) ((us) * `SFPE_LINK_MHZ)
`define SFPE_HOST_DIV 4
`endif

/* File: common/sfpe_pkg.sv */
// types used by the device end of the flash link
package sfpe_pkg;
    typedef enum logic [4:0] {
        SFPE_OP_NONE = 5'b0_0001,
        SFPE_OP_PAGE = 5'b0_0010,
        SFPE_OP_ERASE = 5'b0_0100,
        SFPE_OP_CHIP = 5'b0_1000,
        SFPE_OP_WEN = 5'b1_0000
    } sfpe_op_t;
    typedef enum logic [2:0] {
        SFPE_SIZE_4K = 3'b001,
        SFPE_SIZE_32K = 3'b010,
        SFPE_SIZE_64K = 3'b100
    } sfpe_size_t;
endpackage : sfpe_pkg

/* File: common/sfpe_if.sv */
// serial link between host controller and flash device
`timescale 1ns/1ps
interface sfpe_if;
    logic sck;
    logic cs_n;
    logic [3:0] io_host_o;
    logic [3:0] io_host_oe;
    logic [3:0] io_dev_o;
    logic [3:0] io_dev_oe;
    logic [3:0] io;
    assign io = (io_host_o & io_host_oe) | (io_dev_o & io_dev_oe) | ~(io_host_oe | io_dev_oe);
    modport host (output sck, output cs_n, output io_host_o, output io_host_oe, input io);
    modport dev (input sck, input cs_n, output io_dev_o, output io_dev_oe, input io);
endinterface : sfpe_if

/* File: hdl/sfpe_dev.sv */
// flash device end: command decode, checks, timed cycle, status
`timescale 1ns/1ps
`include "sfpe_params.svh"
module sfpe_dev #(
    parameter int ADDR_W = 20,
    parameter int PAGE_W = 8,
    parameter int DEPTH = 1 << ADDR_W
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // async reset, high
    sfpe_if.dev lnk, // serial link, clocked by sck
    input wire logic quad_enable_bit_i, // quad enable setting
    input wire logic [2:0] block_protect_i, // high, mid, low levels
    input wire logic protect_complement_i, // complement select
    input wire logic small_region_protect_select_i, // sector granularity
    input wire logic top_bottom_select_i, // protect from bottom
    input wire logic [1:0] cr_mode_set_i, // 01 quad, 10 dual continuous entry
    input wire logic [1:0] continuous_read_control_bits_i, // control bits for entry
    input wire logic cr_mode_load_i, // load continuous read state
    output logic busy_o, // busy status bit
    output logic write_enable_latch_o, // latch status bit
    output logic cont_read_o, // continuous read active
    output logic [7:0] status_o // status byte
);
    typedef struct packed {
        logic [2:0] cs_s;
        logic [7:0] sh;
        logic [5:0] bits;
        logic [5:0] bytes;
        logic [7:0] op;
        logic [23:0] addr;
        logic quad;
        logic cr;
        logic cr_dual;
        logic release_bit;
        logic write_enable_latch;
        logic busy;
        logic [23:0] tmr;
        sfpe_pkg::sfpe_op_t pend;
        sfpe_pkg::sfpe_size_t size;
        logic [23:0] eaddr;
        logic erasing;
        logic [7:0] stat;
    } dev_st_t;
    dev_st_t q, d;
    logic [7:0] mem [DEPTH];
    logic [3:0] io_in;
    logic [7:0] byte_in;
    logic [5:0] nb;
    logic full_byte, mem_we;
    logic [ADDR_W-1:0] mem_a;
    logic [7:0] mem_v;
    logic prot;
    logic [2:0] lvl;
    logic [23:0] base;
    assign io_in = lnk.io;
    always_comb begin
        nb = q.quad ? q.bits + 6'd4 : q.bits + 6'd1;
        byte_in = q.quad ? {q.sh[3:0], io_in} : {q.sh[6:0], io_in[0]};
        full_byte = (nb[2:0] == 3'd0);
    end
    always_comb begin
        lvl = block_protect_i;
        base = q.addr;
        prot = 1'b0;
        if (lvl != 3'd0) begin
            if (small_region_protect_select_i)
                prot = top_bottom_select_i ? (base[19:12] < 8'd1 << lvl[1:0]) :
                    (base[19:12] >= 8'hFF - (8'd1 << lvl[1:0]) + 8'd1);
            else
                prot = top_bottom_select_i ? (base[19:16] < 4'(lvl)) :
                    (base[19:16] >= 4'd15 - 4'(lvl) + 4'd1);
        end
        if (protect_complement_i)
            prot = ~prot;
    end
    always_comb begin
        d = q;
        mem_we = 1'b0;
        mem_a = q.addr[ADDR_W-1:0];
        mem_v = byte_in & mem[q.addr[ADDR_W-1:0]];
        d.cs_s = {q.cs_s[1:0], lnk.cs_n};
        if (cr_mode_load_i) begin
            d.cr = (continuous_read_control_bits_i == `SFPE_CR_KEEP);
            d.cr_dual = cr_mode_set_i[1];
            d.release_bit = 1'b0;
        end
        if (!lnk.cs_n) begin
            d.sh = byte_in;
            d.bits = nb;
            if (full_byte) begin
                d.bytes = (q.bytes == 6'd63) ? q.bytes : q.bytes + 6'd1;
                if (q.bytes == 6'd0) begin
                    d.op = byte_in;
                    if (q.cr && byte_in != `SFPE_OP_CRRST)
                        d.op = 8'h00;
                    if (byte_in == `SFPE_OP_QPROG && quad_enable_bit_i && !q.cr)
                        d.quad = 1'b1;
                end else if (q.bytes <= 6'd3) begin
                    d.addr = {q.addr[15:0], byte_in};
                end else if (!q.busy && q.write_enable_latch && !prot &&
                             (q.op == `SFPE_OP_PROG || q.op == `SFPE_OP_QPROG)) begin
                    mem_we = 1'b1;
                    d.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + 8'd1;
                end
            end
        end else begin
            if (q.bytes != 6'd0 && !q.busy) begin
                if (q.op == `SFPE_OP_CRRST && q.bits[2:0] == 3'd0 &&
                    q.bytes == (q.cr_dual ? 6'd2 : 6'd1)) begin
                    d.release_bit = 1'b1;
                    d.cr = 1'b0;
                end
                if (q.bits[2:0] == 3'd0 && q.write_enable_latch && !q.cr) begin
                    if (q.op == `SFPE_OP_WREN && q.bytes == 6'd1)
                        d.write_enable_latch = 1'b1;
                    if ((q.op == `SFPE_OP_PROG || q.op == `SFPE_OP_QPROG) &&
                        q.bytes >= 6'd5 && !prot) begin
                        d.busy = 1'b1;
                        d.tmr = 24'(`SFPE_CYC(`SFPE_PROG_US));
                    end
                    if (q.bytes == 6'd4 && !prot) begin
                        if (q.op == `SFPE_OP_SECT) begin
                            d.busy = 1'b1; d.size = sfpe_pkg::SFPE_SIZE_4K;
                            d.tmr = 24'(`SFPE_CYC(`SFPE_SECT_US));
                        end else if (q.op == `SFPE_OP_BLK32) begin
                            d.busy = 1'b1; d.size = sfpe_pkg::SFPE_SIZE_32K;
                            d.tmr = 24'(`SFPE_CYC(`SFPE_BLK32_US));
                        end else if (q.op == `SFPE_OP_BLK64) begin
                            d.busy = 1'b1; d.size = sfpe_pkg::SFPE_SIZE_64K;
                            d.tmr = 24'(`SFPE_CYC(`SFPE_BLK64_US));
                        end
                    end
                    if ((q.op == `SFPE_OP_CHIP_A || q.op == `SFPE_OP_CHIP_B) &&
                        q.bytes == 6'd1 && block_protect_i == 3'd0 && !protect_complement_i) begin
                        d.busy = 1'b1;
                        d.size = sfpe_pkg::SFPE_SIZE_64K;
                        d.addr = 24'h00_0000;
                        d.pend = sfpe_pkg::SFPE_OP_CHIP;
                        d.tmr = 24'(`SFPE_CYC(`SFPE_CHIP_US));
                    end
                end else if (q.op == `SFPE_OP_WREN && q.bytes == 6'd1 && q.bits[2:0] == 3'd0)
                    d.write_enable_latch = 1'b1;
                if (d.busy && !q.busy && q.op != `SFPE_OP_PROG && q.op != `SFPE_OP_QPROG) begin
                    d.erasing = 1'b1;
                    d.eaddr = 24'h00_0000;
                end
            end
            d.bits = 6'd0;
            d.bytes = 6'd0;
            d.quad = 1'b0;
        end
        if (q.erasing) begin
            mem_we = 1'b1;
            mem_v = `SFPE_ERASED;
            case (q.size)
                sfpe_pkg::SFPE_SIZE_4K: mem_a = ADDR_W'({q.addr[23:12], q.eaddr[11:0]});
                sfpe_pkg::SFPE_SIZE_32K: mem_a = ADDR_W'({q.addr[23:15], q.eaddr[14:0]});
                default: mem_a = (q.pend == sfpe_pkg::SFPE_OP_CHIP) ? q.eaddr[ADDR_W-1:0] :
                    ADDR_W'({q.addr[23:16], q.eaddr[15:0]});
            endcase
            d.eaddr = q.eaddr + 24'd1;
            if (q.eaddr[ADDR_W-1:0] == '1 || (q.pend != sfpe_pkg::SFPE_OP_CHIP &&
                ((q.size == sfpe_pkg::SFPE_SIZE_4K && q.eaddr[11:0] == 12'hFFF) ||
                 (q.size == sfpe_pkg::SFPE_SIZE_32K && q.eaddr[14:0] == 15'h7FFF) ||
                 (q.size == sfpe_pkg::SFPE_SIZE_64K && q.eaddr[15:0] == 16'hFFFF))))
                d.erasing = 1'b0;
        end
        if (q.busy && lnk.cs_n) begin
            if (q.tmr != 24'd0)
                d.tmr = q.tmr - 24'd1;
            else if (!q.erasing) begin
                d.busy = 1'b0;
                d.write_enable_latch = 1'b0;
                d.pend = sfpe_pkg::SFPE_OP_NONE;
            end
        end
        d.stat = {6'd0, d.write_enable_latch, d.busy};
    end
    always_ff @(posedge lnk.sck or posedge rst_i) begin
        if (rst_i) begin
            q <= '{pend: sfpe_pkg::SFPE_OP_NONE, size: sfpe_pkg::SFPE_SIZE_4K, default: '0};
        end else begin
            q <= d;
        end
    end
    always_ff @(posedge lnk.sck) begin
        if (mem_we)
            mem[mem_a] <= mem_v;
    end
    logic [2:0] sync_busy, sync_wel, sync_cr;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_busy <= 3'd0;
            sync_wel <= 3'd0;
            sync_cr <= 3'd0;
            status_o <= 8'h00;
        end else begin
            sync_busy <= {sync_busy[1:0], q.busy};
            sync_wel <= {sync_wel[1:0], q.write_enable_latch};
            sync_cr <= {sync_cr[1:0], q.cr};
            status_o <= {6'd0, sync_wel[1], sync_busy[1]};
        end
    end
    assign busy_o = sync_busy[2];
    assign write_enable_latch_o = sync_wel[2];
    assign cont_read_o = sync_cr[2];
    assign lnk.io_dev_o = 4'h0;
    assign lnk.io_dev_oe = 4'h0;
endmodule : sfpe_dev

/* File: hdl/sfpe_host.sv */
// host controller end: frames commands on the serial link
`timescale 1ns/1ps
`include "sfpe_params.svh"
module sfpe_host (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // async reset, high
    sfpe_if.host lnk, // serial link
    input wire logic req_i, // start a command, pulse
    input wire logic [7:0] op_i, // opcode
    input wire logic [23:0] addr_i, // address
    input wire logic has_addr_i, // send address bytes
    input wire logic [7:0] nbytes_i, // data bytes to send
    input wire logic [7:0] data_i, // data byte
    input wire logic quad_i, // send address and data on four lines
    input wire logic dual_rst_i, // mode reset uses sixteen clocks
    output logic data_take_o, // data byte consumed
    output logic done_o // frame finished, pulse
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_SHIFT = 3'b010,
        HS_END = 3'b100
    } hs_state_t;
    typedef struct packed {
        hs_state_t st;
        logic [7:0] sh;
        logic [3:0] bit_n;
        logic [8:0] left;
        logic [1:0] div;
        logic sck;
        logic cs_n;
        logic quad;
        logic phase_op;
        logic [23:0] addr;
        logic [1:0] abytes;
        logic take;
        logic done;
        logic [3:0] io;
        logic [3:0] oe;
        logic booted;
    } host_st_t;
    host_st_t q, d;
    always_comb begin
        d = q;
        d.take = 1'b0;
        d.done = 1'b0;
        case (q.st)
            HS_IDLE: begin
                // link clock runs free so the device can time its cycle
                d.div = q.div + 2'd1;
                if (q.div == 2'd1)
                    d.sck = 1'b1;
                if (q.div == 2'd3)
                    d.sck = 1'b0;
                if (req_i || !q.booted) begin
                    d.sh = q.booted ? op_i : `SFPE_OP_CRRST;
                    d.addr = addr_i;
                    d.abytes = has_addr_i && q.booted ? 2'd3 : 2'd0;
                    d.phase_op = !q.booted || op_i == `SFPE_OP_CRRST;
                    d.left = d.phase_op ? (dual_rst_i ? 9'd1 : 9'd0) : {1'b0, nbytes_i};
                    d.quad = 1'b0;
                    d.sck = 1'b0;
                    d.bit_n = 4'd0;
                    d.booted = 1'b1;
                    d.cs_n = 1'b0;
                    d.oe = 4'b0001;
                    d.io = {3'd0, d.sh[7]};
                    d.div = 2'd0;
                    d.st = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                d.div = q.div + 2'd1;
                if (q.div == 2'd1)
                    d.sck = 1'b1;
                if (q.div == 2'd3) begin
                    d.sck = 1'b0;
                    d.sh = q.quad ? {q.sh[3:0], 4'h0} : {q.sh[6:0], 1'b0};
                    d.bit_n = q.bit_n + (q.quad ? 4'd4 : 4'd1);
                    if (d.bit_n == 4'd8) begin
                        d.bit_n = 4'd0;
                        d.quad = quad_i;
                        d.oe = quad_i ? 4'hF : 4'h1;
                        if (q.abytes != 2'd0) begin
                            d.sh = q.addr[23:16];
                            d.addr = {q.addr[15:0], 8'h00};
                            d.abytes = q.abytes - 2'd1;
                        end else if (q.left != 9'd0) begin
                            d.sh = q.phase_op ? `SFPE_OP_CRRST : data_i;
                            d.take = !q.phase_op;
                            d.left = q.left - 9'd1;
                        end else begin
                            d.st = HS_END;
                        end
                    end
                    d.io = d.quad ? d.sh[7:4] : {3'd0, d.sh[7]};
                end
            end
            HS_END: begin
                d.cs_n = 1'b1;
                d.oe = 4'h0;
                d.done = !q.cs_n;
                d.div = q.div + 2'd1;
                if (q.div == 2'd1)
                    d.sck = 1'b1;
                // one rising edge with select high lets the device close the frame
                if (q.div == 2'd3) begin
                    d.sck = 1'b0;
                    d.st = HS_IDLE;
                end
            end
            default: d.st = HS_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{st: HS_IDLE, cs_n: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end
    assign lnk.sck = q.sck;
    assign lnk.cs_n = q.cs_n;
    assign lnk.io_host_o = q.io;
    assign lnk.io_host_oe = q.oe;
    assign data_take_o = q.take;
    assign done_o = q.done;
endmodule : sfpe_host

/* File: test/sfpe_link_sva.sv */
// checker for the serial link and the device status outputs
`timescale 1ns/1ps
module sfpe_link_sva (
    input logic clk_i, // system clock
    input logic rst_i, // async reset, high
    input logic sck, // link clock from host
    input logic cs_n, // select, active low
    input logic [3:0] io, // resolved data lines
    input logic [3:0] io_host_oe, // host drive enables
    input logic done_o, // host frame end pulse
    input logic busy_o, // device busy
    input logic write_enable_latch_o, // device latch
    input logic cont_read_o, // continuous read active
    input logic [7:0] status_o // status byte
);
    localparam int MIN_BUSY = 390;
    logic sck_q;
    logic [15:0] bits_q;
    logic [15:0] first_q;
    logic [15:0] busy_cnt_q;
    // bit count and first sixteen single-line bits of a frame
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_q <= 1'b0;
            bits_q <= 16'h0000;
            first_q <= 16'h0000;
            busy_cnt_q <= 16'h0000;
        end else begin
            sck_q <= sck;
            busy_cnt_q <= busy_o ? busy_cnt_q + 16'h0001 : 16'h0000;
            if (cs_n) begin
                bits_q <= 16'h0000;
                first_q <= 16'h0000;
            end else if (sck && !sck_q) begin
                bits_q <= bits_q + ((io_host_oe == 4'hf) ? 16'h0004 : 16'h0001);
                if (bits_q < 16'h0010) begin
                    first_q <= {first_q[14:0], io[0]};
                end
            end
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence frame_end_s;
        $rose(cs_n);
    endsequence
    sequence wren_end_s;
        frame_end_s ##0 (bits_q == 16'h0008 && first_q[7:0] == 8'h06 && !busy_o && !cont_read_o);
    endsequence
    sequence release_end_s;
        frame_end_s ##0 (cont_read_o && ((bits_q == 16'h0008 && first_q[7:0] == 8'hff)
            || (bits_q == 16'h0010 && first_q == 16'hffff)));
    endsequence
    status_map_a: assert property (status_o == {6'h00, write_enable_latch_o, busy_o})
        else $error("status byte does not match flags");
    busy_wel_a: assert property ($rose(busy_o) |-> write_enable_latch_o)
        else $error("busy started without latch");
    wel_clear_a: assert property ($fell(busy_o) |-> ##[0:2] !write_enable_latch_o)
        else $error("latch not cleared at cycle end");
    busy_start_a: assert property ($rose(busy_o) |-> $past(cs_n, 2))
        else $error("busy started inside a frame");
    busy_min_a: assert property ($fell(busy_o) |-> busy_cnt_q >= MIN_BUSY)
        else $error("timed cycle too short");
    frame_done_a: assert property (frame_end_s |-> ##[0:2] done_o)
        else $error("select rose without frame end");
    byte_bound_a: assert property (frame_end_s |-> bits_q[2:0] == 3'h0 && bits_q != 16'h0000)
        else $error("select rose off a byte boundary");
    wren_set_a: assert property (wren_end_s |-> ##[1:24] write_enable_latch_o)
        else $error("enable opcode not taken msb first");
    cr_block_a: assert property ($rose(write_enable_latch_o) |-> !cont_read_o)
        else $error("opcode decoded in continuous mode");
    cr_release_a: assert property (release_end_s |-> ##[1:24] !cont_read_o)
        else $error("mode reset did not release");
endmodule : sfpe_link_sva

/* File: test/serial_flash_program_erase_tb.sv */
// self-checking bench: host and device joined over the link
`timescale 1ns/1ps
module serial_flash_program_erase_tb;
    logic clk_i = 1'b1;
    logic rst_i = 1'b0;
    logic req_i = 1'b0;
    logic [7:0] op_i = 8'h00;
    logic [23:0] addr_i = 24'h00_0000;
    logic has_addr_i = 1'b0;
    logic [7:0] nbytes_i = 8'h00;
    logic [7:0] data_i = 8'h5a;
    logic quad_i = 1'b0;
    logic dual_rst_i = 1'b0;
    logic data_take_o;
    logic done_o;
    logic quad_en = 1'b0;
    logic [2:0] prot_level = 3'h0;
    logic prot_inv = 1'b0;
    logic prot_small = 1'b0;
    logic prot_from_top = 1'b0;
    logic [1:0] cr_set = 2'h0;
    logic [1:0] cr_bits = 2'h0;
    logic cr_load = 1'b0;
    logic busy_o;
    logic latch_o;
    logic cont_read_o;
    logic [7:0] status_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] ops [4] = '{8'h52, 8'hd8, 8'hc7, 8'h60};
    sfpe_if lnk_if ();
    sfpe_host u_sfpe_host (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk_if), .req_i(req_i),
        .op_i(op_i), .addr_i(addr_i), .has_addr_i(has_addr_i), .nbytes_i(nbytes_i),
        .data_i(data_i), .quad_i(quad_i), .dual_rst_i(dual_rst_i),
        .data_take_o(data_take_o), .done_o(done_o));
    sfpe_dev #(.ADDR_W(16)) u_sfpe_dev (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk_if),
        .quad_enable_bit_i(quad_en), .block_protect_i(prot_level),
        .protect_complement_i(prot_inv), .small_region_protect_select_i(prot_small),
        .top_bottom_select_i(prot_from_top), .cr_mode_set_i(cr_set),
        .continuous_read_control_bits_i(cr_bits), .cr_mode_load_i(cr_load),
        .busy_o(busy_o), .write_enable_latch_o(latch_o), .cont_read_o(cont_read_o),
        .status_o(status_o));
    sfpe_link_sva u_sfpe_link_sva (.clk_i(clk_i), .rst_i(rst_i), .sck(lnk_if.sck),
        .cs_n(lnk_if.cs_n), .io(lnk_if.io), .io_host_oe(lnk_if.io_host_oe), .done_o(done_o),
        .busy_o(busy_o), .write_enable_latch_o(latch_o), .cont_read_o(cont_read_o),
        .status_o(status_o));
    always #20 clk_i = ~clk_i;
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic settle;
        repeat (32) @(negedge clk_i);
    endtask : settle
    task automatic wait_done;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk_i);
            if (data_take_o === 1'b1) data_i = data_i + 8'h11;
            if (done_o === 1'b1) break;
        end
        check("frame done", {7'h00, done_o}, 8'h01);
    endtask : wait_done
    task automatic send(input logic [7:0] op, input logic [23:0] addr, input logic has,
                        input logic [7:0] nb, input logic quad, input logic dual);
        @(negedge clk_i);
        op_i = op;
        addr_i = addr;
        has_addr_i = has;
        nbytes_i = nb;
        quad_i = quad;
        dual_rst_i = dual;
        req_i = 1'b1;
        @(negedge clk_i);
        req_i = 1'b0;
        wait_done();
        settle();
    endtask : send
    task automatic do_cmd(input logic wren, input logic [7:0] op, input logic [23:0] addr,
                          input logic has, input logic [7:0] nb, input logic quad);
        if (wren) send(8'h06, 24'h00_0000, 1'b0, 8'h00, 1'b0, 1'b0);
        send(op, addr, has, nb, quad, 1'b0);
    endtask : do_cmd
    task automatic wait_busy(input logic level, input int limit);
        for (int i = 0; i < limit; i++) begin
            @(negedge clk_i);
            if (busy_o === level) break;
        end
    endtask : wait_busy
    task automatic reset_dut;
        @(negedge clk_i);
        rst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        wait_done();
        settle();
    endtask : reset_dut
    task automatic enter_cr(input logic [1:0] set, input logic [1:0] bits);
        @(negedge clk_i);
        cr_set = set;
        cr_bits = bits;
        cr_load = 1'b1;
        repeat (8) @(negedge clk_i);
        cr_load = 1'b0;
        settle();
    endtask : enter_cr
    initial begin
        reset_dut();
        check("status after reset", status_o, 8'h00);
        check("cont after reset", {7'h00, cont_read_o}, 8'h00);
        do_cmd(1'b0, 8'h02, 24'h00_0010, 1'b1, 8'h04, 1'b0);
        check("program no latch", status_o, 8'h00);
        do_cmd(1'b1, 8'h02, 24'h00_00fe, 1'b1, 8'h04, 1'b0);
        check("program busy", status_o, 8'h03);
        wait_busy(1'b0, 3000);
        check("program done", status_o, 8'h00);
        prot_level = 3'h7;
        do_cmd(1'b1, 8'h20, 24'h0F_1000, 1'b1, 8'h00, 1'b0);
        check("erase protected", status_o, 8'h02);
        prot_level = 3'h1;
        do_cmd(1'b1, 8'hc7, 24'h00_0000, 1'b0, 8'h00, 1'b0);
        check("chip erase protected", status_o, 8'h02);
        prot_level = 3'h0;
        do_cmd(1'b1, 8'h32, 24'h00_0200, 1'b1, 8'h04, 1'b1);
        check("quad without enable", status_o, 8'h02);
        quad_en = 1'b1;
        do_cmd(1'b1, 8'h32, 24'h00_0200, 1'b1, 8'h04, 1'b1);
        check("quad program busy", status_o, 8'h03);
        wait_busy(1'b0, 3000);
        check("quad program done", status_o, 8'h00);
        do_cmd(1'b1, 8'h20, 24'h00_2000, 1'b1, 8'h00, 1'b0);
        check("sector erase busy", status_o, 8'h03);
        wait_busy(1'b0, 20000);
        check("sector erase done", status_o, 8'h00);
        for (int i = 0; i < 4; i++) begin
            do_cmd(1'b1, ops[i], 24'h00_8000, (i < 2), 8'h00, 1'b0);
            check("erase busy", status_o, 8'h03);
            reset_dut();
            check("busy cut by reset", status_o, 8'h00);
        end
        enter_cr(2'h1, 2'h2);
        check("quad cont entry", {7'h00, cont_read_o}, 8'h01);
        do_cmd(1'b1, 8'h02, 24'h00_0000, 1'b1, 8'h01, 1'b0);
        check("opcode ignored", status_o, 8'h00);
        send(8'hff, 24'h00_0000, 1'b0, 8'h00, 1'b0, 1'b0);
        check("quad release", {7'h00, cont_read_o}, 8'h00);
        send(8'h06, 24'h00_0000, 1'b0, 8'h00, 1'b0, 1'b0);
        check("opcode after release", status_o, 8'h02);
        enter_cr(2'h2, 2'h2);
        check("dual cont entry", {7'h00, cont_read_o}, 8'h01);
        send(8'hff, 24'h00_0000, 1'b0, 8'h00, 1'b0, 1'b1);
        check("dual release", {7'h00, cont_read_o}, 8'h00);
        enter_cr(2'h1, 2'h0);
        check("bits not kept", {7'h00, cont_read_o}, 8'h00);
        give_verdict();
    end
endmodule : serial_flash_program_erase_tb
